// *** design/pdor_pkg.sv ***
// Package with register map, field layout and reset values of the port register block
package pdor_pkg;

    // ------------------------------------------------------------------
    // Register indices; the byte address is four times the index
    // ------------------------------------------------------------------
    localparam int PDOR_ADDR_W = 8;
    localparam logic [PDOR_ADDR_W-1:0] PDOR_IDX_P4_OUT = 8'h00;
    localparam logic [PDOR_ADDR_W-1:0] PDOR_IDX_REV = 8'h13;
    localparam logic [PDOR_ADDR_W-1:0] PDOR_IDX_P3_DIR = 8'h01;
    localparam logic [PDOR_ADDR_W-1:0] PDOR_IDX_P4_DIR = 8'h02;
    localparam logic [PDOR_ADDR_W-1:0] PDOR_IDX_P3_OUT = 8'h03;
    localparam logic [PDOR_ADDR_W-1:0] PDOR_ADDR_P4_OUT = PDOR_IDX_P4_OUT << 2;
    localparam logic [PDOR_ADDR_W-1:0] PDOR_ADDR_REV = PDOR_IDX_REV << 2;
    localparam logic [PDOR_ADDR_W-1:0] PDOR_ADDR_P3_DIR = PDOR_IDX_P3_DIR << 2;
    localparam logic [PDOR_ADDR_W-1:0] PDOR_ADDR_P4_DIR = PDOR_IDX_P4_DIR << 2;
    localparam logic [PDOR_ADDR_W-1:0] PDOR_ADDR_P3_OUT = PDOR_IDX_P3_OUT << 2;

    // ------------------------------------------------------------------
    // Field layout and reset values
    // ------------------------------------------------------------------
    localparam int PDOR_P3_PINS = 8;
    localparam int PDOR_P4_PINS = 6;
    localparam int PDOR_REG_W = 8;
    localparam int PDOR_REV_W = 16;
    localparam logic [PDOR_REG_W-1:0] PDOR_DIR_RST = 8'h00;
    localparam logic [PDOR_REG_W-1:0] PDOR_OUT_RST = 8'h00;
    localparam logic [7:0] PDOR_REV_HIGH = 8'h00;
    localparam logic [31:0] PDOR_RDATA_RST = 32'h00000000;

    // Arbitrary neutral revision code
    localparam logic [7:0] PDOR_REV_DEFAULT = 8'h5A;

endpackage : pdor_pkg

// *** design/pdor_pad_ctl.sv ***
// Per-pin drive, enable and pull-up control for one port
`timescale 1ns/1ps
`default_nettype none

module pdor_pad_ctl #(
    parameter int PINS = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [PINS-1:0] dir_i,
    input wire logic [PINS-1:0] val_i,
    output logic [PINS-1:0] pin_out,
    output logic [PINS-1:0] pin_oe,
    output logic [PINS-1:0] pin_pullup_en
);

    // ------------------------------------------------------------------
    // Pin control, registered so the pads change one cycle after a write
    // ------------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < PINS; g = g + 1) begin : g_pin
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    pin_out[g] <= 1'b0;
                    pin_oe[g] <= 1'b0;
                    pin_pullup_en[g] <= 1'b0;
                end else begin
                    // Output pins drive the stored value
                    pin_oe[g] <= dir_i[g];
                    // Input pins drive nothing, so the data line is held low
                    pin_out[g] <= dir_i[g] & val_i[g];
                    // Pull-up only on inputs, chosen by the same value bit
                    pin_pullup_en[g] <= ~dir_i[g] & val_i[g];
                end
            end

            a_pin_drive: assert property (@(posedge pclk) disable iff (!presetn)
                dir_i[g] |=> (pin_oe[g] && pin_out[g] == $past(val_i[g]) && !pin_pullup_en[g]))
                else $error("output pin not driving its value");

            a_pin_input: assert property (@(posedge pclk) disable iff (!presetn)
                !dir_i[g] |=> (!pin_oe[g] && !pin_out[g]))
                else $error("input pin still driven");

            a_pin_pullup: assert property (@(posedge pclk) disable iff (!presetn)
                !dir_i[g] |=> (pin_pullup_en[g] == $past(val_i[g])))
                else $error("pull-up does not follow value bit on input pin");
        end
    endgenerate

endmodule : pdor_pad_ctl

`default_nettype wire

// *** design/pdor_regs.sv ***
// APB register block for port 3 and port 4 direction, output value and revision
//
// Chosen here: the APB register port.
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - A direction bit of 1 makes its pin an output driven with the matching output value bit.
// - A direction bit of 0 makes its pin an input that the block does not drive.
// - On an input pin an output value bit of 1 enables the weak pull-up and 0 leaves it floating.
// - Port 3 direction has eight bits, each steering only its own pin.
// - The revision register is 16 bits read-only, revision in the low byte, zero above.
// - The revision value is a fixed constant, not something software can program.
// - The port 4 output register is cleared to zero by every kind of reset.
// - Port 4 output bits 5 to 0 are written by software and read back exactly as stored.
// - Changing port 4 direction leaves the port 4 output register untouched.
// - Port 4 output bits 7 and 6 are reserved and always read zero.
// - Each port 4 output bit is the driven level on outputs and the pull-up choice on inputs.
// - Direction registers clear on every reset except power-fail, which leaves them alone.
module pdor_regs #(
    parameter logic [7:0] SILICON_REV = pdor_pkg::PDOR_REV_DEFAULT
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic pwr_fail_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [pdor_pkg::PDOR_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic [pdor_pkg::PDOR_P3_PINS-1:0] p3_pin_out,
    output logic [pdor_pkg::PDOR_P3_PINS-1:0] p3_pin_oe,
    output logic [pdor_pkg::PDOR_P3_PINS-1:0] p3_pullup_en,
    output logic [pdor_pkg::PDOR_P4_PINS-1:0] p4_pin_out,
    output logic [pdor_pkg::PDOR_P4_PINS-1:0] p4_pin_oe,
    output logic [pdor_pkg::PDOR_P4_PINS-1:0] p4_pullup_en
);
    import pdor_pkg::*;

    // ------------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------------
    logic [PDOR_REG_W-1:0] port3_direction_r;
    logic [PDOR_REG_W-1:0] port4_direction_r;
    logic [PDOR_REG_W-1:0] port3_output_value_r;
    logic [PDOR_REG_W-1:0] port4_output_value_r;
    logic [PDOR_REV_W-1:0] silicon_revision;
    logic [31:0] rdata_nxt;
    logic sel_p4_out;
    logic sel_p3_out;
    logic sel_p3_dir;
    logic sel_p4_dir;
    logic sel_rev;
    logic mapped;
    logic wr_access;
    logic rd_setup;
    logic lane0_wr;

    // ------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------
    // Revision is a wired constant; no flip-flop, so nothing can alter it
    assign silicon_revision = {PDOR_REV_HIGH, SILICON_REV};

    always_comb begin
        sel_p4_out = 1'b0;
        sel_p3_out = 1'b0;
        sel_p3_dir = 1'b0;
        sel_p4_dir = 1'b0;
        sel_rev = 1'b0;
        if (paddr == PDOR_ADDR_P4_OUT) begin
            sel_p4_out = 1'b1;
        end else if (paddr == PDOR_ADDR_P3_OUT) begin
            sel_p3_out = 1'b1;
        end else if (paddr == PDOR_ADDR_P3_DIR) begin
            sel_p3_dir = 1'b1;
        end else if (paddr == PDOR_ADDR_P4_DIR) begin
            sel_p4_dir = 1'b1;
        end else if (paddr == PDOR_ADDR_REV) begin
            sel_rev = 1'b1;
        end
    end

    assign mapped = sel_p4_out | sel_p3_out | sel_p3_dir | sel_p4_dir | sel_rev;
    assign wr_access = psel & penable & pwrite & mapped;
    assign rd_setup = psel & ~penable & ~pwrite;
    // All writable registers are at most one byte wide, so only lane 0 matters
    assign lane0_wr = wr_access & pstrb[0];

    // ------------------------------------------------------------------
    // APB answer
    // ------------------------------------------------------------------
    // Zero wait states: every access completes in its first access cycle
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~mapped;

    always_comb begin
        rdata_nxt = PDOR_RDATA_RST;
        if (sel_p4_out) begin
            rdata_nxt = {24'h000000, port4_output_value_r};
        end else if (sel_p3_out) begin
            rdata_nxt = {24'h000000, port3_output_value_r};
        end else if (sel_p3_dir) begin
            rdata_nxt = {24'h000000, port3_direction_r};
        end else if (sel_p4_dir) begin
            rdata_nxt = {24'h000000, port4_direction_r};
        end else if (sel_rev) begin
            rdata_nxt = {16'h0000, silicon_revision};
        end
    end

    // Read data is captured in the setup cycle so it is stable in the access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= PDOR_RDATA_RST;
        end else if (rd_setup) begin
            prdata <= rdata_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Direction registers
    // ------------------------------------------------------------------
    // Power-fail reset is deliberately absent here: directions survive it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port3_direction_r <= PDOR_DIR_RST;
        end else if (lane0_wr && sel_p3_dir) begin
            port3_direction_r <= pwdata[PDOR_REG_W-1:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port4_direction_r <= PDOR_DIR_RST;
        end else if (lane0_wr && sel_p4_dir) begin
            port4_direction_r <= {2'b00, pwdata[PDOR_P4_PINS-1:0]};
        end
    end

    // ------------------------------------------------------------------
    // Output value registers
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port3_output_value_r <= PDOR_OUT_RST;
        end else if (pwr_fail_rst) begin
            port3_output_value_r <= PDOR_OUT_RST;
        end else if (lane0_wr && sel_p3_out) begin
            port3_output_value_r <= pwdata[PDOR_REG_W-1:0];
        end
    end

    // Only a write to this address or a reset touches it; direction writes never do
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port4_output_value_r <= PDOR_OUT_RST;
        end else if (pwr_fail_rst) begin
            port4_output_value_r <= PDOR_OUT_RST;
        end else if (lane0_wr && sel_p4_out) begin
            port4_output_value_r <= {2'b00, pwdata[PDOR_P4_PINS-1:0]};
        end
    end

    // ------------------------------------------------------------------
    // Pin control
    // ------------------------------------------------------------------
    pdor_pad_ctl #(
        .PINS(PDOR_P3_PINS)
    ) u_p3_pads (
        .pclk(pclk),
        .presetn(presetn),
        .dir_i(port3_direction_r),
        .val_i(port3_output_value_r),
        .pin_out(p3_pin_out),
        .pin_oe(p3_pin_oe),
        .pin_pullup_en(p3_pullup_en)
    );

    pdor_pad_ctl #(
        .PINS(PDOR_P4_PINS)
    ) u_p4_pads (
        .pclk(pclk),
        .presetn(presetn),
        .dir_i(port4_direction_r[PDOR_P4_PINS-1:0]),
        .val_i(port4_output_value_r[PDOR_P4_PINS-1:0]),
        .pin_out(p4_pin_out),
        .pin_oe(p4_pin_oe),
        .pin_pullup_en(p4_pullup_en)
    );

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    a_rev_read_value: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && penable && !pwrite && sel_rev) |-> (prdata == {16'h0000, 8'h00, SILICON_REV}))
        else $error("revision read returned wrong value");

    a_rev_write_ignored: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && penable && pwrite && sel_rev && !pwr_fail_rst) |=>
            ($stable(port3_direction_r) && $stable(port4_direction_r)
             && $stable(port3_output_value_r) && $stable(port4_output_value_r)))
        else $error("write to revision changed some register");

    a_p4_reserved_zero: assert property (@(posedge pclk) disable iff (!presetn)
        port4_output_value_r[7:6] == 2'b00)
        else $error("reserved port 4 bits not zero");

    a_p4_write_store: assert property (@(posedge pclk) disable iff (!presetn)
        (lane0_wr && sel_p4_out && !pwr_fail_rst) |=>
            (port4_output_value_r == {2'b00, $past(pwdata[5:0])}))
        else $error("port 4 output write not stored");

    a_p4_dir_keeps: assert property (@(posedge pclk) disable iff (!presetn)
        (lane0_wr && sel_p4_dir && !pwr_fail_rst) |=> $stable(port4_output_value_r))
        else $error("port 4 direction write disturbed output value");

    a_pfail_keeps_dir: assert property (@(posedge pclk) disable iff (!presetn)
        (pwr_fail_rst && !lane0_wr) |=>
            ($stable(port3_direction_r) && $stable(port4_direction_r)))
        else $error("power-fail reset changed a direction register");

    a_pfail_clears_out: assert property (@(posedge pclk) disable iff (!presetn)
        pwr_fail_rst |=> (port4_output_value_r == 8'h00))
        else $error("port 4 output not cleared by power-fail reset");

    a_p3_dir_bits: assert property (@(posedge pclk) disable iff (!presetn)
        (lane0_wr && sel_p3_dir) |=> (port3_direction_r == $past(pwdata[7:0])))
        else $error("port 3 direction write not stored bit for bit");

    a_p3_pin_timing: assert property (@(posedge pclk) disable iff (!presetn)
        (lane0_wr && sel_p3_dir) ##1 !(lane0_wr && sel_p3_dir) |=>
            (p3_pin_oe == $past(pwdata[7:0], 2)))
        else $error("port 3 enables did not follow write one cycle later");

    a_unmapped_err: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && penable && !mapped) |-> (pslverr && pready))
        else $error("unmapped access not answered with error");

    // ------------------------------------------------------------------
    // Read path checks
    // ------------------------------------------------------------------
    // The copy is taken one edge early, so a power-fail in setup is excluded
    a_p4_read_back: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && penable && !pwrite && sel_p4_out && !$past(pwr_fail_rst)) |->
            (prdata == {24'h000000, port4_output_value_r}))
        else $error("port 4 output read does not match stored value");

    a_p3_dir_read: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && penable && !pwrite && sel_p3_dir) |->
            (prdata == {24'h000000, port3_direction_r}))
        else $error("port 3 direction read does not match stored value");

    a_rd_upper_zero: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && penable && !pwrite) |-> (prdata[31:16] == 16'h0000))
        else $error("read data upper half not zero");

    a_rev_no_error: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && penable && sel_rev) |-> !pslverr)
        else $error("revision access answered with error");

    a_err_only_access: assert property (@(posedge pclk) disable iff (!presetn)
        !(psel && penable) |-> !pslverr)
        else $error("error flag raised outside an access cycle");

    // ------------------------------------------------------------------
    // Refused writes
    // ------------------------------------------------------------------
    // A cleared lane 0 strobe or an unmapped address must leave all state alone
    a_refused_write_keeps: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && penable && pwrite && (!pstrb[0] || !mapped) && !pwr_fail_rst) |=>
            ($stable(port3_direction_r) && $stable(port4_direction_r)
             && $stable(port3_output_value_r) && $stable(port4_output_value_r)))
        else $error("refused write changed a register");

    a_p4_dir_store: assert property (@(posedge pclk) disable iff (!presetn)
        (lane0_wr && sel_p4_dir) |=> (port4_direction_r == {2'b00, $past(pwdata[5:0])}))
        else $error("port 4 direction write not stored");

    a_p3_out_pfail: assert property (@(posedge pclk) disable iff (!presetn)
        pwr_fail_rst |=> (port3_output_value_r == 8'h00))
        else $error("port 3 output not cleared by power-fail reset");

    // ------------------------------------------------------------------
    // Pad timing
    // ------------------------------------------------------------------
    // Pads lag the registers by exactly one edge, on every cycle
    a_p3_pad_follow: assert property (@(posedge pclk) disable iff (!presetn)
        1'b1 |=> (p3_pin_oe == $past(port3_direction_r)
            && p3_pin_out == ($past(port3_direction_r) & $past(port3_output_value_r))
            && p3_pullup_en == (~$past(port3_direction_r) & $past(port3_output_value_r))))
        else $error("port 3 pads do not follow the registers one cycle later");

    a_p4_pad_follow: assert property (@(posedge pclk) disable iff (!presetn)
        1'b1 |=> (p4_pin_oe == $past(port4_direction_r[5:0])
            && p4_pin_out == ($past(port4_direction_r[5:0])
                & $past(port4_output_value_r[5:0]))
            && p4_pullup_en == (~$past(port4_direction_r[5:0])
                & $past(port4_output_value_r[5:0]))))
        else $error("port 4 pads do not follow the registers one cycle later");

endmodule : pdor_regs

`default_nettype wire

// *** verification/tb_pdor_regs.sv ***
// Self-checking testbench for the port direction, output value and revision registers
`timescale 1ns/1ps
`default_nettype none

module tb_pdor_regs;
    import pdor_pkg::*;

    // ------------------------------------------------------------------
    // Signals and design instance
    // ------------------------------------------------------------------
    // Arbitrary revision code, chosen to differ from the design default
    localparam logic [7:0] REV_VAL = 8'h3C;
    localparam int MAX_CYCLES = 3000;

    logic pclk, presetn, pwr_fail_rst, psel, penable, pwrite, pready, pslverr, err;
    logic [PDOR_ADDR_W-1:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] pstrb;
    logic [7:0] p3_pin_out, p3_pin_oe, p3_pullup_en;
    logic [5:0] p4_pin_out, p4_pin_oe, p4_pullup_en;
    int num_errors, comparisons, cycles;

    pdor_regs #(.SILICON_REV(REV_VAL)) i_dut (
        .pclk(pclk), .presetn(presetn), .pwr_fail_rst(pwr_fail_rst),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .p3_pin_out(p3_pin_out), .p3_pin_oe(p3_pin_oe),
        .p3_pullup_en(p3_pullup_en), .p4_pin_out(p4_pin_out),
        .p4_pin_oe(p4_pin_oe), .p4_pullup_en(p4_pullup_en)
    );

    always #5 pclk = ~pclk;

    // Hang guard; the whole sequence needs about 140 cycles
    always @(posedge pclk) begin
        cycles++;
        if (cycles == MAX_CYCLES) begin
            num_errors++;
            end_sim();
        end
    end

    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task automatic end_sim();
        if (num_errors == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : end_sim

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // One APB transfer; waits for pready with a bounded count
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic [3:0] s);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 50) begin
            @(posedge pclk);
            n++;
        end
        if (n == 50) begin
            num_errors++;
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 4'hF);
    endtask : wr

    task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input logic exp_err);
        apb(1'b0, a, 32'h0000_0000, 4'hF);
        chk(rd, exp);
        chk({31'h0000_0000, err}, {31'h0000_0000, exp_err});
    endtask : rdc

    // Pin expectations: drive where direction is 1, pull-up where it is 0 and the value bit is 1
    task automatic chk_pins(input logic [7:0] d3, input logic [7:0] v3,
                            input logic [5:0] d4, input logic [5:0] v4);
        chk({24'h000000, p3_pin_oe}, {24'h000000, d3});
        chk({24'h000000, p3_pin_out}, {24'h000000, d3 & v3});
        chk({24'h000000, p3_pullup_en}, {24'h000000, ~d3 & v3});
        chk({26'h0000000, p4_pin_oe}, {26'h0000000, d4});
        chk({26'h0000000, p4_pin_out}, {26'h0000000, d4 & v4});
        chk({26'h0000000, p4_pullup_en}, {26'h0000000, ~d4 & v4});
    endtask : chk_pins

    // ------------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------------
    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        pwr_fail_rst = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        pstrb = 4'h0;
        num_errors = 0;
        comparisons = 0;
        cycles = 0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        rdc(PDOR_ADDR_P4_OUT, 32'h0000_0000, 1'b0);
        rdc(PDOR_ADDR_P3_DIR, 32'h0000_0000, 1'b0);
        rdc(PDOR_ADDR_REV, {16'h0000, 8'h00, REV_VAL}, 1'b0);
        chk_pins(8'h00, 8'h00, 6'h00, 6'h00);
        wr(PDOR_ADDR_REV, 32'h0000_FFFF);
        rdc(PDOR_ADDR_REV, {16'h0000, 8'h00, REV_VAL}, 1'b0);
        wr(PDOR_ADDR_P4_OUT, 32'h0000_00FF);
        rdc(PDOR_ADDR_P4_OUT, 32'h0000_003F, 1'b0);
        wr(PDOR_ADDR_P3_OUT, 32'h0000_000F);
        wr(PDOR_ADDR_P3_DIR, 32'h0000_00A5);
        #1;
        chk_pins(8'h00, 8'h0F, 6'h00, 6'h3F);
        @(posedge pclk);
        #1;
        chk_pins(8'hA5, 8'h0F, 6'h00, 6'h3F);
        for (int i = 0; i < 8; i++) begin
            wr(PDOR_ADDR_P3_DIR, 32'h0000_0001 << i);
            rdc(PDOR_ADDR_P3_DIR, 32'h0000_0001 << i, 1'b0);
            chk_pins(8'h01 << i, 8'h0F, 6'h00, 6'h3F);
        end
        wr(PDOR_ADDR_P4_DIR, 32'h0000_003F);
        wr(PDOR_ADDR_P4_OUT, 32'h0000_002A);
        @(posedge pclk);
        #1;
        chk_pins(8'h80, 8'h0F, 6'h3F, 6'h2A);
        wr(PDOR_ADDR_P4_DIR, 32'h0000_0000);
        rdc(PDOR_ADDR_P4_OUT, 32'h0000_002A, 1'b0);
        chk_pins(8'h80, 8'h0F, 6'h00, 6'h2A);
        // Refused accesses: unmapped, misaligned, byte lane 0 off
        rdc(8'h10, 32'h0000_0000, 1'b1);
        rdc(8'h01, 32'h0000_0000, 1'b1);
        apb(1'b1, PDOR_ADDR_P4_OUT, 32'h0000_0015, 4'hE);
        rdc(PDOR_ADDR_P4_OUT, 32'h0000_002A, 1'b0);
        // Power-fail reset keeps directions but clears output values
        wr(PDOR_ADDR_P3_DIR, 32'h0000_00A5);
        @(posedge pclk);
        pwr_fail_rst <= 1'b1;
        @(posedge pclk);
        pwr_fail_rst <= 1'b0;
        rdc(PDOR_ADDR_P4_OUT, 32'h0000_0000, 1'b0);
        rdc(PDOR_ADDR_P3_DIR, 32'h0000_00A5, 1'b0);
        chk_pins(8'hA5, 8'h00, 6'h00, 6'h00);
        // Full reset in mid-run clears everything at once
        wr(PDOR_ADDR_P4_DIR, 32'h0000_003F);
        wr(PDOR_ADDR_P4_OUT, 32'h0000_0015);
        @(posedge pclk);
        presetn <= 1'b0;
        #1;
        chk_pins(8'h00, 8'h00, 6'h00, 6'h00);
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rdc(PDOR_ADDR_P3_DIR, 32'h0000_0000, 1'b0);
        rdc(PDOR_ADDR_P4_DIR, 32'h0000_0000, 1'b0);
        rdc(PDOR_ADDR_P4_OUT, 32'h0000_0000, 1'b0);
        end_sim();
    end

endmodule : tb_pdor_regs

`default_nettype wire
